/* lfad_pkg.sv */
package lfad_pkg;

   // ==========================================
   // Clock and timing
   localparam int CLK_MHZ = 250;
   localparam int CLK_HZ = CLK_MHZ * 1_000_000;
   localparam int CARRIER_HZ = 125_000;
   localparam int FREQ_MIN_HZ = 90_000;
   localparam int FREQ_MAX_HZ = 160_000;
   localparam int PROTECT_DEBOUNCE_TIME_US = 20;
   localparam int T_WAKE_US = 64;
   localparam int T_ACK_US = 256;
   localparam int T_ERR_US = 128;
   localparam int T_END_US = 16_000;
   localparam int DEB_CYC = PROTECT_DEBOUNCE_TIME_US * CLK_MHZ;
   localparam int WAKE_CYC = T_WAKE_US * CLK_MHZ;
   localparam int ACK_CYC = T_ACK_US * CLK_MHZ;
   localparam int ERR_CYC = T_ERR_US * CLK_MHZ;
   localparam int END_CYC = T_END_US * CLK_MHZ;
   localparam int TMR_W = 22;

   // ==========================================
   // Carrier period in clock cycles
   localparam int PER_W = 12;
   localparam logic [11:0] PER_NOM = 12'(CLK_HZ / CARRIER_HZ);
   localparam logic [11:0] PER_MAX = 12'(CLK_HZ / FREQ_MIN_HZ);
   localparam logic [11:0] PER_MIN = 12'((CLK_HZ + FREQ_MAX_HZ - 1) / FREQ_MAX_HZ);
   localparam logic [11:0] PER_SAT = 12'hfff;

   // ==========================================
   // Duty cycle codes, 256 is full on
   localparam logic [8:0] DUTY_FULL = 9'h100;
   localparam logic [8:0] DUTY_START = 9'h080;
   localparam logic [8:0] DUTY_RAMP_STEP = 9'h028;
   localparam logic [8:0] DUTY_REG_MAX = 9'h0dc;
   localparam logic [8:0] DUTY_REG_MIN = 9'h024;
   localparam logic [8:0] DUTY_REG_STEP = 9'h004;
   localparam logic [8:0] DUTY_FLOOR = 9'h008;

   // ==========================================
   // Register map and fields
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PERIOD = 8'h08;
   localparam logic [7:0] ADDR_DUTY = 8'h0c;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int CTRL_TRACK_BIT = 0;
   localparam int CTRL_SKIP_BIT = 1;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_KLINE_BIT = 4;
   localparam int ST_UV_BIT = 8;
   localparam int ST_FREQ_BIT = 9;
   localparam int ST_PEAK_BIT = 10;
   localparam int ST_PROT_BIT = 11;
   localparam int ST_LOWDUTY_BIT = 12;
   localparam int PERIOD_MEAS_LSB = 16;

   // ==========================================
   // Synchronised pin inputs
   localparam int NSYNC = 9;
   localparam int IN_LINE = 0;
   localparam int IN_LEVEL = 1;
   localparam int IN_ZC = 2;
   localparam int IN_PEAK = 3;
   localparam int IN_SKIP = 4;
   localparam int IN_DIAG = 5;
   localparam int IN_LD = 6;
   localparam int IN_OT = 7;
   localparam int IN_UV = 8;
   localparam logic [8:0] SYNC_RESET = 9'h001;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_WAKE,
      ST_DRIVE,
      ST_PAUSE,
      ST_PROTECT,
      ST_ACK
   } lfad_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } lfad_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lfad_apb_rsp_s;

   typedef struct packed {
      logic under_volt;
      logic over_temp;
      logic load_dump;
      logic over_peak_diag;
      logic over_peak_skip;
      logic over_peak;
      logic zero_cross;
   } lfad_analog_s;

endpackage : lfad_pkg

/* lfad_top.sv */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
// Contract
// - Reset puts all logic in known state
// - Level select picks controller or K-line
// - One clock drives interface and driver
// - Idle carrier free-runs near 125 kHz
// - Active carrier follows antenna zero crossings
// - Line low requests square-wave drive
// - Lower duty to hold peak current
// - Regulation 14-86 percent, lower above (code lets duty fall to 3 percent, only flags below 14)
// - Burst starts 50 percent, ramps up
// - Skip pulse above peak plus 20
// - Protection only while driving
// - Low side on before acknowledge (after a protection trip, off until the pulse starts)
// - Protection trip turns both switches off
// - Trip only after debounce while driving
// - Load dump is a protection event
// - Overtemperature is a protection event
// - Errors held, reported at end
// - Flag undervoltage during transmission
// - Flag frequency outside 90-160 kHz
// - Flag peak above set plus 15
// - Clean end pulls line low 256 us
// - Failed end pulls line low 128 us
// - Line high stops drive, output grounded
module lfad_top
   import lfad_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = DEB_CYC,
   parameter int unsigned WAKE_CYCLES = WAKE_CYC,
   parameter int unsigned ACK_CYCLES = ACK_CYC,
   parameter int unsigned ERR_CYCLES = ERR_CYC,
   parameter int unsigned END_CYCLES = END_CYC
)
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire lfad_apb_req_s apb_in,
   output lfad_apb_rsp_s apb_out,
   input wire logic one_wire_line_in,
   output logic one_wire_line_out,
   output logic one_wire_line_oe_out,
   input wire logic line_level_select_in,
   output logic line_level_kline_out,
   input wire logic [11:0] osc_ref_resistor_input_in,
   input wire lfad_analog_s analog_in,
   output logic antenna_drive_hs_out,
   output logic antenna_drive_ls_out
);

   // ==========================================
   // Input synchronisers
   logic [NSYNC-1:0] raw_w;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   logic [NSYNC-1:0] s3_q;
   logic [NSYNC-1:0] filt_q;

   assign raw_w = {analog_in, line_level_select_in, one_wire_line_in};

   // Three stages, accept once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge ref_clk_in or posedge rst_in)
         begin
            if (rst_in)
            begin
               s1_q[gi] <= SYNC_RESET[gi];
               s2_q[gi] <= SYNC_RESET[gi];
               s3_q[gi] <= SYNC_RESET[gi];
               filt_q[gi] <= SYNC_RESET[gi];
            end
            else
            begin
               s1_q[gi] <= raw_w[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
                  filt_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   // Named views of filtered inputs
   wire line_high_w = filt_q[IN_LINE];
   wire zc_w = filt_q[IN_ZC];
   wire peak_w = filt_q[IN_PEAK];
   wire skip_cmp_w = filt_q[IN_SKIP];
   wire diag_peak_w = filt_q[IN_DIAG];
   wire uv_w = filt_q[IN_UV];
   wire prot_cond_w = filt_q[IN_LD] | filt_q[IN_OT];

   // ==========================================
   // Registers and state
   lfad_state_e state_q;
   lfad_state_e state_d;
   logic [TMR_W-1:0] tmr_q;
   logic [TMR_W-1:0] deb_q;
   logic [1:0] ctrl_q;
   logic kline_q;
   logic uv_err_q;
   logic freq_err_q;
   logic peak_err_q;
   logic prot_err_q;
   logic err_sel_q;
   logic line_oe_q;
   logic hs_q;
   logic ls_q;
   logic zc_prev_q;
   logic [1:0] zc_cnt_q;
   logic [11:0] meas_q;
   logic [11:0] per_meas_q;
   logic [11:0] ph_q;
   logic [8:0] duty_q;
   logic reg_on_q;
   logic skip_q;
   logic pk_seen_q;
   logic sk_seen_q;
   logic [31:0] rdata_q;
   logic slverr_q;

   // ==========================================
   // Oscillator and period tracking
   wire driving_w = (state_q == ST_DRIVE);
   wire zc_rise_w = zc_w & ~zc_prev_q;
   wire trk_valid_w = (zc_cnt_q == 2'h2);
   wire meas_ok_w = (per_meas_q >= PER_MIN) && (per_meas_q <= PER_MAX);
   wire use_trk_w = driving_w && ctrl_q[CTRL_TRACK_BIT] && trk_valid_w && meas_ok_w;
   wire [11:0] per_w = use_trk_w ? per_meas_q : osc_ref_resistor_input_in;
   wire cyc_end_w = (ph_q >= per_w - 12'h001);
   wire [20:0] on_prod_w = 21'(per_w) * 21'(duty_q);
   wire [12:0] on_len_w = on_prod_w[20:8];

   wire freq_bad_w = driving_w && ((trk_valid_w && !meas_ok_w) || (meas_q > PER_MAX));

   // Period counter between zero-crossing rising edges
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         zc_prev_q <= 1'b0;
         zc_cnt_q <= 2'h0;
         meas_q <= 12'h000;
         per_meas_q <= PER_NOM;
      end
      else
      begin
         zc_prev_q <= zc_w;
         if (!driving_w)
         begin
            zc_cnt_q <= 2'h0;
            meas_q <= 12'h000;
         end
         else if (zc_rise_w)
         begin
            meas_q <= 12'h001;
            if (zc_cnt_q != 2'h0)
               per_meas_q <= meas_q;
            if (zc_cnt_q != 2'h2)
               zc_cnt_q <= zc_cnt_q + 2'h1;
         end
         else if (meas_q != PER_SAT)
            meas_q <= meas_q + 12'h001;
      end
   end

   // ==========================================
   // Duty cycle regulation
   wire [8:0] ramp_w = (duty_q + DUTY_RAMP_STEP > DUTY_FULL) ? DUTY_FULL
                       : duty_q + DUTY_RAMP_STEP;
   wire [8:0] up_w = (duty_q + DUTY_REG_STEP > DUTY_REG_MAX) ? DUTY_REG_MAX
                     : duty_q + DUTY_REG_STEP;
   wire [8:0] down_w = (duty_q < DUTY_FLOOR + DUTY_REG_STEP) ? DUTY_FLOOR
                       : duty_q - DUTY_REG_STEP;
   wire [8:0] duty_next_w = pk_seen_q ? down_w : (reg_on_q ? up_w : ramp_w);

   // Carrier phase, per-cycle duty and skip decisions
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ph_q <= 12'h000;
         duty_q <= DUTY_START;
         reg_on_q <= 1'b0;
         skip_q <= 1'b0;
         pk_seen_q <= 1'b0;
         sk_seen_q <= 1'b0;
      end
      // Each burst starts at half duty
      else if (!driving_w)
      begin
         ph_q <= 12'h000;
         duty_q <= DUTY_START;
         reg_on_q <= 1'b0;
         skip_q <= 1'b0;
         pk_seen_q <= 1'b0;
         sk_seen_q <= 1'b0;
      end
      else if (cyc_end_w)
      begin
         ph_q <= 12'h000;
         duty_q <= duty_next_w;
         reg_on_q <= reg_on_q | pk_seen_q;
         skip_q <= !reg_on_q && (sk_seen_q || skip_cmp_w) && ctrl_q[CTRL_SKIP_BIT];
         pk_seen_q <= peak_w;
         sk_seen_q <= 1'b0;
      end
      else
      begin
         ph_q <= ph_q + 12'h001;
         pk_seen_q <= pk_seen_q | peak_w;
         sk_seen_q <= sk_seen_q | skip_cmp_w;
      end
   end

   // ==========================================
   // Transmission sequencing
   wire tmr_wake_w = (tmr_q >= TMR_W'(WAKE_CYCLES - 1));
   wire tmr_end_w = (tmr_q >= TMR_W'(END_CYCLES - 1));
   wire [TMR_W-1:0] pulse_len_w = err_sel_q ? TMR_W'(ERR_CYCLES) : TMR_W'(ACK_CYCLES);
   wire tmr_pulse_w = (tmr_q >= pulse_len_w - TMR_W'(1));
   wire trip_w = driving_w && prot_cond_w && (deb_q >= TMR_W'(DEB_CYCLES - 1));
   wire err_any_w = uv_err_q | freq_err_q | peak_err_q | prot_err_q;
   wire start_tx_w = (state_q == ST_WAKE) && !line_high_w && tmr_wake_w;

   // Next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_STANDBY:
            if (!line_high_w)
               state_d = ST_WAKE;
         ST_WAKE:
            if (line_high_w)
               state_d = ST_STANDBY;
            else if (tmr_wake_w)
               state_d = ST_DRIVE;
         ST_DRIVE:
            if (trip_w)
               state_d = ST_PROTECT;
            else if (line_high_w)
               state_d = ST_PAUSE;
         ST_PAUSE:
            if (!line_high_w)
               state_d = ST_DRIVE;
            else if (tmr_end_w)
               state_d = ST_ACK;
         ST_PROTECT:
            if (line_high_w && tmr_end_w)
               state_d = ST_ACK;
         ST_ACK:
            if (tmr_pulse_w)
               state_d = ST_STANDBY;
         default:
            state_d = ST_STANDBY;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= ST_STANDBY;
         tmr_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         if ((state_d != state_q) || ((state_q == ST_PROTECT) && !line_high_w))
            tmr_q <= '0;
         // Saturate at all ones so the long end-of-transmission count is reachable
         else if (tmr_q != '1)
            tmr_q <= tmr_q + TMR_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         deb_q <= '0;
      else if (!driving_w || !prot_cond_w)
         deb_q <= '0;
      else if (!deb_q[TMR_W-1])
         deb_q <= deb_q + TMR_W'(1);
   end

   // ==========================================
   // Held diagnosis flags, set beats clear
   // Clear on new transmission
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         uv_err_q <= 1'b0;
         freq_err_q <= 1'b0;
         peak_err_q <= 1'b0;
         prot_err_q <= 1'b0;
      end
      else
      begin
         uv_err_q <= (uv_err_q & ~start_tx_w) | (driving_w & uv_w);
         freq_err_q <= (freq_err_q & ~start_tx_w) | freq_bad_w;
         peak_err_q <= (peak_err_q & ~start_tx_w) | (driving_w & diag_peak_w);
         prot_err_q <= (prot_err_q & ~start_tx_w) | trip_w;
      end
   end

   // ==========================================
   // Pin outputs
   wire hs_d_w = driving_w && !skip_q && ({1'b0, ph_q} < on_len_w);
   // Ground between end and pulse
   // Low side follows the next state into the pulse, so it lines up with the line pull
   wire ls_d_w = (driving_w && !hs_d_w) || (state_q == ST_PAUSE) || (state_d == ST_ACK);

   // Gate drives, acknowledge pulse and level mode
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         hs_q <= 1'b0;
         ls_q <= 1'b0;
         line_oe_q <= 1'b0;
         err_sel_q <= 1'b0;
         kline_q <= 1'b0;
      end
      else
      begin
         hs_q <= hs_d_w;
         ls_q <= ls_d_w;
         line_oe_q <= (state_d == ST_ACK);
         if (state_q != ST_ACK)
            err_sel_q <= err_any_w;
         kline_q <= filt_q[IN_LEVEL];
      end
   end

   assign antenna_drive_hs_out = hs_q;
   assign antenna_drive_ls_out = ls_q;
   assign one_wire_line_out = 1'b0;
   assign one_wire_line_oe_out = line_oe_q;
   assign line_level_kline_out = kline_q;

   // ==========================================
   // APB slave, data latched in setup cycle
   wire setup_w = apb_in.psel && !apb_in.penable;
   wire access_w = apb_in.psel && apb_in.penable;
   wire hit_ctrl_w = (apb_in.paddr == ADDR_CTRL);
   wire hit_stat_w = (apb_in.paddr == ADDR_STATUS);
   wire hit_per_w = (apb_in.paddr == ADDR_PERIOD);
   wire hit_duty_w = (apb_in.paddr == ADDR_DUTY);
   wire hit_w = hit_ctrl_w | hit_stat_w | hit_per_w | hit_duty_w;
   logic [31:0] status_w;
   logic [31:0] rd_mux_w;

   // Status word
   always_comb
   begin
      status_w = 32'h0000_0000;
      status_w[ST_STATE_LSB +: 3] = state_q;
      status_w[ST_KLINE_BIT] = kline_q;
      status_w[ST_UV_BIT] = uv_err_q;
      status_w[ST_FREQ_BIT] = freq_err_q;
      status_w[ST_PEAK_BIT] = peak_err_q;
      status_w[ST_PROT_BIT] = prot_err_q;
      status_w[ST_LOWDUTY_BIT] = reg_on_q && (duty_q < DUTY_REG_MIN);
   end

   // Read selection
   assign rd_mux_w = hit_ctrl_w ? {30'h0, ctrl_q}
                   : hit_stat_w ? status_w
                   : hit_per_w ? {4'h0, per_meas_q, 4'h0, per_w}
                   : hit_duty_w ? {23'h0, duty_q}
                   : 32'h0000_0000;

   // Register writes and latched read data
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ctrl_q <= CTRL_RESET;
         rdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end
      else
      begin
         if (setup_w)
         begin
            rdata_q <= apb_in.pwrite ? 32'h0000_0000 : rd_mux_w;
            slverr_q <= !hit_w;
         end
         if (access_w && apb_in.pwrite && hit_ctrl_w)
            ctrl_q <= apb_in.pwdata[1:0];
      end
   end

   assign apb_out.prdata = rdata_q;
   assign apb_out.pready = access_w;
   assign apb_out.pslverr = access_w && slverr_q;

endmodule : lfad_top

/* lfad_top_monitor.sv */
`timescale 1ns/1ps
module lfad_top_monitor
   import lfad_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = DEB_CYC,
   parameter int unsigned ACK_CYCLES = ACK_CYC,
   parameter int unsigned ERR_CYCLES = ERR_CYC
)
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic one_wire_line_in,
   input wire logic one_wire_line_oe_out,
   input wire logic line_level_select_in,
   input wire logic line_level_kline_out,
   input wire lfad_analog_s analog_in,
   input wire logic antenna_drive_hs_out,
   input wire logic antenna_drive_ls_out
);
   // ==========================================
   // Helper counters
   logic [23:0] oe_cnt_q;
   logic [23:0] oe_cnt_d;
   logic [23:0] prot_cnt_q;
   logic [23:0] prot_cnt_d;
   wire logic on_w = antenna_drive_hs_out | antenna_drive_ls_out;
   wire logic prot_w = analog_in.load_dump | analog_in.over_temp;
   // Pulse length runs while the line is pulled, protection time while driving
   assign oe_cnt_d = one_wire_line_oe_out ? oe_cnt_q + 24'h1 : 24'h0;
   assign prot_cnt_d = (prot_w && on_w && !one_wire_line_oe_out && !one_wire_line_in) ?
      prot_cnt_q + 24'h1 : 24'h0;
   // Counter registers
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         oe_cnt_q <= 24'h0;
         prot_cnt_q <= 24'h0;
      end
      else
      begin
         oe_cnt_q <= oe_cnt_d;
         prot_cnt_q <= prot_cnt_d;
      end
   end

   // ==========================================
   // Assertions
   AST_RST_OFF: assert property (@(posedge ref_clk_in) rst_in |->
      !antenna_drive_hs_out && !antenna_drive_ls_out && !one_wire_line_oe_out)
      else $error("outputs active during reset");
   AST_KLINE_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      line_level_select_in [*8] |-> line_level_kline_out)
      else $error("kline level not taken");
   AST_KLINE_CLR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !line_level_select_in [*8] |-> !line_level_kline_out)
      else $error("controller level not taken");
   AST_LINE_HIGH_STOP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      one_wire_line_in [*8] |-> !antenna_drive_hs_out)
      else $error("high side on with line high");
   AST_ACK_LOW_SIDE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      one_wire_line_oe_out |-> antenna_drive_ls_out && !antenna_drive_hs_out)
      else $error("low side off during line pulse");
   AST_PULSE_LEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(one_wire_line_oe_out) |->
      (oe_cnt_q == 24'(ACK_CYCLES)) || (oe_cnt_q == 24'(ERR_CYCLES)))
      else $error("line pulse length wrong");
   AST_DEB_MAX: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      prot_cnt_q <= 24'(DEB_CYCLES + 8))
      else $error("no switch-off after protection");
   AST_DEB_MIN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(on_w) && !one_wire_line_in |-> prot_cnt_q >= 24'(DEB_CYCLES))
      else $error("switch-off before debounce");
   AST_NO_SHOOT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !(antenna_drive_hs_out && antenna_drive_ls_out))
      else $error("both half-bridge switches on");
endmodule : lfad_top_monitor

bind lfad_top lfad_top_monitor #(
   .DEB_CYCLES(DEB_CYCLES),
   .ACK_CYCLES(ACK_CYCLES),
   .ERR_CYCLES(ERR_CYCLES)
) u_mon (
   .ref_clk_in(ref_clk_in),
   .rst_in(rst_in),
   .one_wire_line_in(one_wire_line_in),
   .one_wire_line_oe_out(one_wire_line_oe_out),
   .line_level_select_in(line_level_select_in),
   .line_level_kline_out(line_level_kline_out),
   .analog_in(analog_in),
   .antenna_drive_hs_out(antenna_drive_hs_out),
   .antenna_drive_ls_out(antenna_drive_ls_out)
);

/* lfad_ctrl_model.sv */
`timescale 1ns/1ps
module lfad_ctrl_model
(
   input wire logic ref_clk_in,
   input wire logic req_in,
   input wire logic dev_data_in,
   input wire logic dev_oe_in,
   output logic line_out
);
   logic req_q = 1'b0;
   // Request changes just after an edge
   always @(posedge ref_clk_in)
   begin
      req_q <= req_in;
   end
   // low requests drive, release stops it
   assign line_out = !req_q && (dev_oe_in ? dev_data_in : 1'b1);
endmodule : lfad_ctrl_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   import lfad_pkg::*;
   localparam int DEB = 10;
   localparam int ACK = 40;
   localparam int ERR = 20;
   localparam int PER = 2000;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b0;
   lfad_apb_req_s apb_req = '0;
   lfad_apb_rsp_s apb_rsp;
   lfad_analog_s ana = '0;
   logic req = 1'b0;
   logic sel = 1'b0;
   logic line;
   logic dout;
   logic doe;
   logic hs;
   logic ls;
   int n_fail = 0;
   int n_tests = 0;
   int zc_cnt = 0;
   logic [31:0] seed = 32'h871b;
   logic [31:0] rd;
   logic er;
   logic [31:0] d;

   // ==========================================
   // Clock, design and line partner
   always #2 ref_clk_in = ~ref_clk_in;
   lfad_top #(.DEB_CYCLES(DEB), .WAKE_CYCLES(20), .ACK_CYCLES(ACK), .ERR_CYCLES(ERR),
      .END_CYCLES(200)) uut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .apb_in(apb_req), .apb_out(apb_rsp),
      .one_wire_line_in(line), .one_wire_line_out(dout), .one_wire_line_oe_out(doe),
      .line_level_select_in(sel), .line_level_kline_out(),
      .osc_ref_resistor_input_in(12'h7d0), .analog_in(ana),
      .antenna_drive_hs_out(hs), .antenna_drive_ls_out(ls));
   lfad_ctrl_model u_ctrl (.ref_clk_in(ref_clk_in), .req_in(req), .dev_data_in(dout),
      .dev_oe_in(doe), .line_out(line));
   // Antenna current zero crossings
   always @(posedge ref_clk_in)
   begin
      zc_cnt <= (zc_cnt == PER / 2 - 1) ? 0 : zc_cnt + 1;
      if (zc_cnt == PER / 2 - 1)
      begin
         ana.zero_cross <= ~ana.zero_cross;
      end
   end

   // ==========================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic int exp_hs(int k);
      return PER * (int'(DUTY_START) + k * int'(DUTY_RAMP_STEP)) / 256;
   endfunction : exp_hs
   function automatic logic [31:0] exp_err(int m);
      return (m == 1) ? 32'h1 : (m == 2) ? 32'h8 : (m == 3) ? 32'h4 : 32'h0;
   endfunction : exp_err
   task summarize();
      $display("Checks %0d, failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   task check(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         n_fail++;
      end
   endtask : check
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge ref_clk_in);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge ref_clk_in);
      apb_req.penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge ref_clk_in);
         i++;
      end
      while (apb_rsp.pready !== 1'b1 && i < 50);
      if (i >= 50)
      begin
         n_fail++;
         summarize();
      end
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb
   task pulse(input logic k, output int n);
      int t;
      t = 0;
      n = 0;
      while ((k ? doe : hs) !== 1'b1 && t < 60000)
      begin
         @(posedge ref_clk_in);
         t++;
      end
      while ((k ? doe : hs) === 1'b1 && n < 60000)
      begin
         @(posedge ref_clk_in);
         n++;
      end
      if (t >= 60000 || n >= 60000)
      begin
         n_fail++;
         summarize();
      end
   endtask : pulse
   task xfer(input int m, input int exp_oe);
      int n;
      int k;
      req <= 1'b1;
      for (k = 0; k < 3; k++)
      begin
         pulse(1'b0, n);
         if (m == 0)
         begin
            check(n, exp_hs(k));
         end
      end
      if (m == 1)
      begin
         ana.under_volt <= 1'b1;
         repeat (30) @(posedge ref_clk_in);
         ana.under_volt <= 1'b0;
      end
      if (m == 2)
      begin
         ana.over_temp <= 1'b1;
         repeat (rnd() % (DEB - 4) + 1) @(posedge ref_clk_in);
         ana.over_temp <= 1'b0;
         repeat (12) @(posedge ref_clk_in);
         check({31'h0, hs | ls}, 32'h1);
         ana.load_dump <= 1'b1;
         repeat (DEB + 12) @(posedge ref_clk_in);
         check({30'h0, hs, ls}, 32'h0);
         ana.load_dump <= 1'b0;
      end
      if (m == 3)
      begin
         ana.over_peak_diag <= 1'b1;
         repeat (30) @(posedge ref_clk_in);
         ana.over_peak_diag <= 1'b0;
      end
      req <= 1'b0;
      repeat (12) @(posedge ref_clk_in);
      check({31'h0, hs}, 32'h0);
      pulse(1'b1, n);
      check(n, exp_oe);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check({28'h0, rd[ST_PROT_BIT:ST_UV_BIT]}, exp_err(m));
   endtask : xfer

   // ==========================================
   // Main sequence
   initial
   begin
      rst_in <= 1'b1;
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd, {30'h0, CTRL_RESET});
      repeat (4)
      begin
         d = rnd();
         apb(1'b1, ADDR_CTRL, d);
         apb(1'b0, ADDR_CTRL, 32'h0);
         check(rd, {30'h0, d[1:0]});
      end
      apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
      apb(1'b0, 8'h10, 32'h0);
      check({31'h0, er}, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h3);
      sel <= d[3];
      repeat (10) @(posedge ref_clk_in);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check({31'h0, rd[ST_KLINE_BIT]}, {31'h0, sel});
      xfer(0, ACK);
      xfer(1, ERR);
      xfer(0, ACK);
      xfer(2, ERR);
      xfer(3, ERR);
      summarize();
   end
endmodule : testbench
